// file: accel_i2c_pkg.sv
// Constants shared by the accelerometer serial slave port
package accel_i2c_pkg;
   // Core clock and line filter timing
   localparam int CLK_HZ = 10_000_000;
   localparam int SPIKE_NS = 50;
   localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
   localparam int SPIKE_CYC_RAW = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SPIKE_CYC = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;

   // Slave addresses selected by the straps {high, low}
   localparam logic [6:0] ADDR_STRAP_00 = 7'h1E;
   localparam logic [6:0] ADDR_STRAP_01 = 7'h1D;
   localparam logic [6:0] ADDR_STRAP_10 = 7'h1C;
   localparam logic [6:0] ADDR_STRAP_11 = 7'h1F;

   // Byte framing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ACK_ADDR,
      ST_WRITE,
      ST_ACK_WR,
      ST_READ,
      ST_ACK_RD,
      ST_IGNORE
   } port_state_e;
endpackage

// file: accel_i2c_slave_port.sv
// Two-wire serial slave port: framing, addressing, acknowledge, register pointer
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Both lines idle high, nobody holds low
// - Start is data fall while clock high
// - Bus busy from start until stop
// - First byte: seven address bits, direction bit
// - Selected only when address matches own
// - Ninth clock of each byte is acknowledge
// - Transmitter releases data during acknowledge
// - Receiver holds data low through ack high
// - No limit on bytes per transfer
// - Device never stretches the clock
// - Stop is data rise while clock high
// - Repeated start accepts a new address
// - Two straps select one of four addresses
// - Spikes of 50 ns or less ignored
// - Works at 100 kHz and 400 kHz
// - Pointer advances by one per data byte
module accel_i2c_slave_port (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bus pins; the clock line is never driven
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Address straps
   input wire logic addr_strap_high,
   input wire logic addr_strap_low,
   // Register side
   output logic [7:0] reg_ptr,
   output logic [7:0] wr_data,
   output logic wr_strobe,
   input wire logic [7:0] rd_data,
   // Status
   output logic bus_busy,
   output logic selected
);
   logic scl_f;
   logic sda_f;
   logic scl_d_reg;
   logic sda_d_reg;
   logic [1:0] strap_meta_reg;
   logic [1:0] strap_sync_reg;
   logic [6:0] own_addr_reg;
   accel_i2c_pkg::port_state_e state_reg;
   logic [7:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic rw_reg;
   logic ptr_loaded_reg;
   logic master_ack_reg;
   logic wr_pend_reg;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   function automatic logic [6:0] strap_addr(input logic [1:0] s);
      case (s)
         2'b00: strap_addr = accel_i2c_pkg::ADDR_STRAP_00;
         2'b01: strap_addr = accel_i2c_pkg::ADDR_STRAP_01;
         2'b10: strap_addr = accel_i2c_pkg::ADDR_STRAP_10;
         default: strap_addr = accel_i2c_pkg::ADDR_STRAP_11;
      endcase
   endfunction

   // Short filter latency leaves room in a fast-mode low phase
   i2c_line_filter #(.STABLE_CYC(accel_i2c_pkg::SPIKE_CYC)) u_scl_filt (
      .clk(clk),
      .rst(rst),
      .line_in(scl_in),
      .line_out(scl_f)
   );

   i2c_line_filter #(.STABLE_CYC(accel_i2c_pkg::SPIKE_CYC)) u_sda_filt (
      .clk(clk),
      .rst(rst),
      .line_in(sda_in),
      .line_out(sda_f)
   );

   // Edge history of the filtered lines
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_f;
         sda_d_reg <= sda_f;
      end
   end

   assign scl_rise = scl_f & ~scl_d_reg;
   assign scl_fall = ~scl_f & scl_d_reg;
   assign start_seen = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
   assign stop_seen = scl_f & scl_d_reg & ~sda_d_reg & sda_f;

   // Straps are sampled continuously, address only follows them while idle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strap_meta_reg <= 2'b00;
         strap_sync_reg <= 2'b00;
         own_addr_reg <= accel_i2c_pkg::ADDR_STRAP_00;
      end else begin
         strap_meta_reg <= {addr_strap_high, addr_strap_low};
         strap_sync_reg <= strap_meta_reg;
         if (state_reg == accel_i2c_pkg::ST_IDLE) begin
            own_addr_reg <= strap_addr(strap_sync_reg);
         end
      end
   end

   // Busy flag spans start to stop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_busy <= 1'b0;
      end else if (stop_seen) begin
         bus_busy <= 1'b0;
      end else if (start_seen) begin
         bus_busy <= 1'b1;
      end
   end

   // Line driver is open drain: only ever pulls low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // Protocol engine; every drive change happens just after a clock fall,
   // so data is ready long before the next rise and no stretching is needed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= accel_i2c_pkg::ST_IDLE;
         shift_reg <= accel_i2c_pkg::BYTE_RESET;
         bit_cnt_reg <= '0;
         rw_reg <= 1'b0;
         ptr_loaded_reg <= 1'b0;
         master_ack_reg <= 1'b0;
         wr_pend_reg <= 1'b0;
         sda_oe <= 1'b0;
         selected <= 1'b0;
         reg_ptr <= accel_i2c_pkg::PTR_RESET;
         wr_data <= accel_i2c_pkg::BYTE_RESET;
         wr_strobe <= 1'b0;
      end else begin
         wr_strobe <= 1'b0;
         if (stop_seen) begin
            state_reg <= accel_i2c_pkg::ST_IDLE;
            sda_oe <= 1'b0;
            selected <= 1'b0;
         end else if (start_seen) begin
            state_reg <= accel_i2c_pkg::ST_ADDR;
            bit_cnt_reg <= '0;
            sda_oe <= 1'b0;
            selected <= 1'b0;
         end else begin
            case (state_reg)
               accel_i2c_pkg::ST_ADDR: begin
                  if (scl_rise) begin
                     shift_reg <= {shift_reg[6:0], sda_f};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == accel_i2c_pkg::BITS_PER_BYTE) begin
                     rw_reg <= shift_reg[0];
                     if (shift_reg[7:1] == own_addr_reg) begin
                        selected <= 1'b1;
                        sda_oe <= 1'b1;
                        state_reg <= accel_i2c_pkg::ST_ACK_ADDR;
                     end else begin
                        state_reg <= accel_i2c_pkg::ST_IGNORE;
                     end
                  end
               end
               accel_i2c_pkg::ST_ACK_ADDR: begin
                  if (scl_fall) begin
                     bit_cnt_reg <= '0;
                     if (rw_reg) begin
                        shift_reg <= rd_data;
                        sda_oe <= ~rd_data[7];
                        state_reg <= accel_i2c_pkg::ST_READ;
                     end else begin
                        sda_oe <= 1'b0;
                        ptr_loaded_reg <= 1'b0;
                        wr_pend_reg <= 1'b0;
                        state_reg <= accel_i2c_pkg::ST_WRITE;
                     end
                  end
               end
               accel_i2c_pkg::ST_WRITE: begin
                  if (scl_rise) begin
                     shift_reg <= {shift_reg[6:0], sda_f};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == accel_i2c_pkg::BITS_PER_BYTE) begin
                     sda_oe <= 1'b1;
                     state_reg <= accel_i2c_pkg::ST_ACK_WR;
                     if (!ptr_loaded_reg) begin
                        reg_ptr <= shift_reg;
                        ptr_loaded_reg <= 1'b1;
                     end else begin
                        wr_data <= shift_reg;
                        wr_strobe <= 1'b1;
                        // Strobe is gone by the ack fall, so remember the byte
                        wr_pend_reg <= 1'b1;
                     end
                  end
               end
               accel_i2c_pkg::ST_ACK_WR: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b0;
                     bit_cnt_reg <= '0;
                     state_reg <= accel_i2c_pkg::ST_WRITE;
                     if (wr_pend_reg) begin
                        reg_ptr <= reg_ptr + 8'h01;
                        wr_pend_reg <= 1'b0;
                     end
                  end
               end
               accel_i2c_pkg::ST_READ: begin
                  if (scl_rise) begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_cnt_reg == accel_i2c_pkg::BITS_PER_BYTE) begin
                        sda_oe <= 1'b0;
                        reg_ptr <= reg_ptr + 8'h01;
                        state_reg <= accel_i2c_pkg::ST_ACK_RD;
                     end else begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sda_oe <= ~shift_reg[6];
                     end
                  end
               end
               accel_i2c_pkg::ST_ACK_RD: begin
                  if (scl_rise) begin
                     master_ack_reg <= ~sda_f;
                  end else if (scl_fall) begin
                     bit_cnt_reg <= '0;
                     if (master_ack_reg) begin
                        shift_reg <= rd_data;
                        sda_oe <= ~rd_data[7];
                        state_reg <= accel_i2c_pkg::ST_READ;
                     end else begin
                        state_reg <= accel_i2c_pkg::ST_IGNORE;
                     end
                  end
               end
               accel_i2c_pkg::ST_IGNORE: begin
                  sda_oe <= 1'b0;
               end
               accel_i2c_pkg::ST_IDLE: begin
                  sda_oe <= 1'b0;
               end
               default: begin
                  state_reg <= accel_i2c_pkg::ST_IDLE;
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: accel_i2c_slave_port_monitor.sv
// Concurrent checks on the pins of the two-wire slave port
`timescale 1ns/10ps
`default_nettype none
module accel_i2c_slave_port_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // Register side and status
   input wire logic wr_strobe,
   input wire logic bus_busy,
   input wire logic selected
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Raw pins held four samples, so filtered edges are real
   sequence s_start;
      scl_in && $fell(sda_in) ##1 (scl_in && !sda_in) [*4];
   endsequence
   sequence s_stop;
      scl_in && $rose(sda_in) ##1 (scl_in && sda_in) [*4];
   endsequence
   sequence s_spike;
      scl_in && !bus_busy && $fell(sda_in) ##1 sda_in;
   endsequence
   property p_idle_rel; !bus_busy |-> !sda_oe; endproperty
   a_idle_rel: assert property (p_idle_rel) else $error("data driven while idle");
   property p_drive_low; sda_oe |-> !sda_out; endproperty
   a_drive_low: assert property (p_drive_low) else $error("data driven high");
   property p_sel_busy; selected |-> bus_busy; endproperty
   a_sel_busy: assert property (p_sel_busy) else $error("selected outside busy");
   property p_strobe_one; wr_strobe |=> !wr_strobe; endproperty
   a_strobe_one: assert property (p_strobe_one) else $error("strobe too long");
   property p_strobe_ack; wr_strobe |-> selected ##[0:2] sda_oe; endproperty
   a_strobe_ack: assert property (p_strobe_ack) else $error("byte not acknowledged");
   property p_start_busy; s_start |-> ##[0:4] bus_busy; endproperty
   a_start_busy: assert property (p_start_busy) else $error("start missed");
   property p_stop_idle; s_stop |-> ##[0:4] (!bus_busy && !selected); endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop missed");
   property p_spike; s_spike |=> !bus_busy [*6]; endproperty
   a_spike: assert property (p_spike) else $error("spike taken as start");
   property p_oe_low; $changed(sda_oe) |-> !scl_in; endproperty
   a_oe_low: assert property (p_oe_low) else $error("data moved in clock high");
endmodule
`default_nettype wire

// file: accel_i2c_slave_port_test.sv
// Self-checking bench for the two-wire slave port
`timescale 1ns/10ps
`default_nettype none
`define CHECK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
   $display("unexpected at %0t: %h vs %h", $time, a, e); end end
module accel_i2c_slave_port_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic addr_strap_high = 1'b0;
   logic addr_strap_low = 1'b0;
   logic [7:0] rd_data = 8'h00;
   logic [7:0] wr_got = 8'h00;
   logic [7:0] reg_ptr, wr_data, ptr, dat, got;
   logic sda_out, sda_oe, wr_strobe, bus_busy, selected, scl_rel, sda_rel, ack;
   wire logic sda = sda_rel & (!sda_oe | sda_out);
   int err_total = 0;
   int checks_done = 0;
   int cycles = 0;
   integer seed = 32'hBA36E53A;
   always #50 clk = ~clk;
   // Register file stand-in: contents derived from the pointer
   always @(negedge clk) rd_data <= reg_ptr ^ 8'hA5;
   always @(posedge clk) if (wr_strobe) wr_got <= wr_data;
   accel_i2c_slave_port accel_i2c_slave_port_inst (.clk(clk), .rst(rst), .scl_in(scl_rel),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_high(addr_strap_high),
      .addr_strap_low(addr_strap_low), .reg_ptr(reg_ptr), .wr_data(wr_data),
      .wr_strobe(wr_strobe), .rd_data(rd_data), .bus_busy(bus_busy), .selected(selected));
   bus_master bus_master_inst (.sda(sda), .scl_rel(scl_rel), .sda_rel(sda_rel));
   function automatic logic [6:0] own_addr(input logic [1:0] s);
      return (s == 2'b00) ? 7'h1E : (s == 2'b01) ? 7'h1D : (s == 2'b10) ? 7'h1C : 7'h1F;
   endfunction
   task automatic finish_test();
      if (err_total == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         err_total++;
         finish_test();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      for (int s = 0; s < 4; s++) begin
         @(negedge clk) {addr_strap_high, addr_strap_low} = s[1:0];
         repeat (8) @(negedge clk);
         ptr = $random(seed);
         dat = $random(seed);
         bus_master_inst.start();
         bus_master_inst.send({own_addr(s[1:0]), 1'b0}, ack);
         `CHECK(ack, 1'b1)
         `CHECK(bus_busy, 1'b1)
         bus_master_inst.send(ptr, ack);
         #1000 `CHECK(reg_ptr, ptr)
         bus_master_inst.send(dat, ack);
         #1000 `CHECK(wr_got, dat)
         bus_master_inst.send(~dat, ack);
         #1000 `CHECK(wr_got, ~dat)
         `CHECK(reg_ptr, ptr + 8'h02)
         bus_master_inst.stop();
         #1000 `CHECK(bus_busy, 1'b0)
         bus_master_inst.start();
         bus_master_inst.send({own_addr(s[1:0]) ^ 7'h02, 1'b1}, ack);
         `CHECK(ack, 1'b0)
         `CHECK(selected, 1'b0)
         bus_master_inst.send(8'h00, ack);
         `CHECK(ack, 1'b0)
         bus_master_inst.stop();
      end
      // Pointer at the top value so the burst wraps
      ptr = 8'hFF;
      bus_master_inst.start();
      bus_master_inst.send({own_addr(2'b11), 1'b0}, ack);
      bus_master_inst.send(ptr, ack);
      bus_master_inst.start();
      bus_master_inst.send({own_addr(2'b11), 1'b1}, ack);
      `CHECK(ack, 1'b1)
      bus_master_inst.recv(1'b0, got);
      `CHECK(got, ptr ^ 8'hA5)
      bus_master_inst.recv(1'b1, got);
      `CHECK(got, (ptr + 8'h01) ^ 8'hA5)
      #1000 `CHECK(sda_oe, 1'b0)
      bus_master_inst.stop();
      #2000 bus_master_inst.spike();
      #1000 `CHECK(bus_busy, 1'b0)
      finish_test();
   end
endmodule
bind accel_i2c_slave_port accel_i2c_slave_port_monitor mon_inst (.clk(clk), .rst(rst),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .wr_strobe(wr_strobe), .bus_busy(bus_busy), .selected(selected));
`default_nettype wire

// file: bus_master.sv
// Behavioural bus master for the two-wire port
`timescale 1ns/10ps
`default_nettype none
module bus_master (
   // Data wire level
   input wire logic sda,
   // Master drives, high means released
   output logic scl_rel,
   output logic sda_rel
);
   // Long low phase: the port answers about 0.5 us after a fall
   localparam int T_LOW = 1600;
   localparam int T_HIGH = 800;
   localparam int T_HOLD = 300;
   initial begin
      scl_rel = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic tick(input logic b, output logic r);
      #(T_HOLD) sda_rel = b;
      #(T_LOW - T_HOLD) scl_rel = 1'b1;
      #(T_HIGH / 2) r = sda;
      #(T_HIGH / 2) scl_rel = 1'b0;
   endtask
   task automatic start();
      #(T_HOLD) sda_rel = 1'b1;
      #(T_LOW) scl_rel = 1'b1;
      #(T_HIGH) sda_rel = 1'b0;
      #(T_HIGH) scl_rel = 1'b0;
   endtask
   task automatic stop();
      #(T_HOLD) sda_rel = 1'b0;
      #(T_LOW - T_HOLD) scl_rel = 1'b1;
      #(T_HIGH) sda_rel = 1'b1;
      #(T_HIGH);
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) tick(d[i], r);
      tick(1'b1, r);
      ack = !r;
   endtask
   task automatic recv(input logic nak, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) tick(1'b1, d[i]);
      tick(nak, r);
   endtask
   // Straddles a core clock edge so the synchroniser really sees it
   task automatic spike();
      #30 sda_rel = 1'b0;
      #40 sda_rel = 1'b1;
   endtask
endmodule
`default_nettype wire

// file: i2c_line_filter.sv
// Two-stage synchroniser followed by a spike filter for one bus line
`timescale 1ns/10ps
`default_nettype none
module i2c_line_filter #(
   parameter int STABLE_CYC = accel_i2c_pkg::SPIKE_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Line
   input wire logic line_in,
   output logic line_out
);
   localparam int CW = $clog2(STABLE_CYC + 2);
   logic meta_reg;
   logic sync_reg;
   logic [CW-1:0] cnt_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
      end else begin
         meta_reg <= line_in;
         sync_reg <= meta_reg;
      end
   end

   // A level must hold longer than a spike before it is passed on
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         line_out <= 1'b1;
      end else if (sync_reg == line_out) begin
         cnt_reg <= '0;
      end else if (cnt_reg == CW'(STABLE_CYC)) begin
         cnt_reg <= '0;
         line_out <= sync_reg;
      end else begin
         cnt_reg <= cnt_reg + CW'(1);
      end
   end
endmodule
`default_nettype wire
